// ---- inc/aors_consts.vh ----
// Functional notes
// [RL1] Eight rate registers at consecutive indices; register k sets the output rate of converter k (channels 2k, 2k+1).
// [RL2] The rate field is bits [3:0]; code 0000 gives the converter no output timing reference.
// [RL3] Codes 0001 to 0100 make the converter follow serial output port 0 to 3.
// [RL4] Code 0101 locks the converter to the DSP core sample rate.
// [RL5] Codes 0110, 0111, 1000 pick the first generator's base rate, twice it and four times it.
// [RL6] Code 1001 picks half and code 1011 a quarter of the first generator's rate.
// [RL7] Code 1010 picks a third and code 1100 a sixth of the second generator's rate.
// [RL8] Each converter resamples any input rate so its output appears at the chosen target rate.
// [RL9] Twenty-four pair-source registers at consecutive indices; register k drives output channels 2k and 2k+1.
// [RL10] Pair registers 0-7 feed channels 0-15 on port 0, registers 8-15 feed channels 16-31 on port 1.
// [RL11] Pair registers 16-19 feed channels 32-39 on port 2, registers 20-23 feed channels 40-47 on port 3.
// [RL12] The converter pick field in bits [5:3] counts only when the source field is 011.
// [RL13] Pick value n routes converter channels 2n and 2n+1 to the first and second output channel.
// [RL14] Each output pair comes from serial inputs, DSP outputs, a converter or the microphones.
// [RL15] Source codes: 000 off, 001 serial inputs, 010 DSP outputs, 011 converter, 100/101 microphone pairs 0/1, 2/3.
// [RL16] In copy and DSP modes source channels 2k and 2k+1 land on output channels 2k and 2k+1 in order.
// [RL17] Rate codes 1101 to 1111 behave like the no-rate code.
`ifndef AORS_CONSTS_VH
`define AORS_CONSTS_VH

// ==========================================
// Register indices (byte address is four times the index)
`define AORS_RATE_IDX_BASE 16'hF140
`define AORS_RATE_IDX_LAST 16'hF147
`define AORS_PAIR_IDX_BASE 16'hF180
`define AORS_PAIR_IDX_LAST 16'hF197
`define AORS_STAT_IDX      16'hF1A0

// ==========================================
// Field layout and reset values
`define AORS_RATE_MSB 3
`define AORS_RATE_LSB 0
`define AORS_SRC_MSB  2
`define AORS_SRC_LSB  0
`define AORS_PICK_MSB 5
`define AORS_PICK_LSB 3
`define AORS_RATE_RST 4'h0
`define AORS_PAIR_RST 6'h00

// ==========================================
// Rate codes
`define AORS_RATE_NONE  4'h0
`define AORS_RATE_PORT0 4'h1
`define AORS_RATE_PORT1 4'h2
`define AORS_RATE_PORT2 4'h3
`define AORS_RATE_PORT3 4'h4
`define AORS_RATE_DSP   4'h5
`define AORS_RATE_G1    4'h6
`define AORS_RATE_G1X2  4'h7
`define AORS_RATE_G1X4  4'h8
`define AORS_RATE_G1D2  4'h9
`define AORS_RATE_G2D3  4'hA
`define AORS_RATE_G1D4  4'hB
`define AORS_RATE_G2D6  4'hC

// ==========================================
// Pair source codes
`define AORS_SRC_OFF  3'h0
`define AORS_SRC_SIN  3'h1
`define AORS_SRC_DSP  3'h2
`define AORS_SRC_CONV 3'h3
`define AORS_SRC_MIC0 3'h4
`define AORS_SRC_MIC1 3'h5

// ==========================================
// Generator dividers and bus answers
`define AORS_G1_X2_PH 4'h1
`define AORS_G1_B_PH  4'h3
`define AORS_G1_D2_PH 4'h7
`define AORS_G1_D4_PH 4'hF
`define AORS_G2_D3_A  3'h2
`define AORS_G2_D6_PH 3'h5
`define AORS_RESP_OK  2'h0
`define AORS_RESP_ERR 2'h2

`endif

// ---- hw/aors_audio_output_routing.v ----
`timescale 1ns/1ps
`include "aors_consts.vh"

module aors_audio_output_routing #(
	parameter AW = 18,
	parameter DW = 32,
	parameter NCONV = 8,
	parameter NPAIR = 24
) (
	// Clock, reset, enable
	input  wire                  aclk,
	input  wire                  aresetn,
	input  wire                  ce,
	// AXI4-Lite write
	input  wire [AW-1:0]         awaddr,
	input  wire [2:0]            awprot,
	input  wire                  awvalid,
	output reg                   awready,
	input  wire [31:0]           wdata,
	input  wire [3:0]            wstrb,
	input  wire                  wvalid,
	output reg                   wready,
	output reg  [1:0]            bresp,
	output reg                   bvalid,
	input  wire                  bready,
	// AXI4-Lite read
	input  wire [AW-1:0]         araddr,
	input  wire [2:0]            arprot,
	input  wire                  arvalid,
	output reg                   arready,
	output reg  [31:0]           rdata,
	output reg  [1:0]            rresp,
	output reg                   rvalid,
	input  wire                  rready,
	// Rate references
	input  wire [3:0]            sout_rate_tick,
	input  wire                  dsp_rate_tick,
	input  wire                  gen1_x4_tick,
	input  wire                  gen2_tick,
	output reg  [NCONV-1:0]      resampler_rate_tick,
	output reg  [NCONV-1:0]      resampler_rate_valid,
	// Audio sources
	input  wire [2*NPAIR*DW-1:0] serial_in_data,
	input  wire [2*NPAIR*DW-1:0] dsp_out_data,
	input  wire [2*NCONV*DW-1:0] resampler_out_data,
	input  wire [4*DW-1:0]       mic_in_data,
	// Serial output channels
	output reg  [2*NPAIR*DW-1:0] serial_out_data,
	output reg  [NPAIR-1:0]      serial_out_pair_active
);

	// ==========================================
	// Configuration storage
	reg  [3:0]  rate_q [0:NCONV-1];
	reg  [5:0]  pair_q [0:NPAIR-1];
	reg  [AW-1:0] aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         aw_held_q;
	reg         w_held_q;
	reg  [3:0]  g1_cnt_q;
	reg  [2:0]  g2_cnt_q;
	integer     i;
	integer     ic;
	integer     ip;

	// ==========================================
	// Address decode
	wire [15:0] wr_idx = aw_addr_q[17:2];
	wire [15:0] rd_idx = araddr[17:2];
	wire [15:0] wr_off_r = wr_idx - `AORS_RATE_IDX_BASE;
	wire [15:0] wr_off_p = wr_idx - `AORS_PAIR_IDX_BASE;
	wire [15:0] rd_off_r = rd_idx - `AORS_RATE_IDX_BASE;
	wire [15:0] rd_off_p = rd_idx - `AORS_PAIR_IDX_BASE;
	wire wr_is_rate = (wr_idx >= `AORS_RATE_IDX_BASE) && (wr_idx <= `AORS_RATE_IDX_LAST);
	wire wr_is_pair = (wr_idx >= `AORS_PAIR_IDX_BASE) && (wr_idx <= `AORS_PAIR_IDX_LAST);
	wire wr_is_stat = (wr_idx == `AORS_STAT_IDX);
	wire rd_is_rate = (rd_idx >= `AORS_RATE_IDX_BASE) && (rd_idx <= `AORS_RATE_IDX_LAST);
	wire rd_is_pair = (rd_idx >= `AORS_PAIR_IDX_BASE) && (rd_idx <= `AORS_PAIR_IDX_LAST);
	wire rd_is_stat = (rd_idx == `AORS_STAT_IDX);
	wire wr_fire = aw_held_q && w_held_q && !bvalid;
	wire wr_map = wr_is_rate || wr_is_pair || wr_is_stat;
	wire rd_map = rd_is_rate || rd_is_pair || rd_is_stat;

	// ==========================================
	// Write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= `AORS_RESP_OK;
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= {AW{1'b0}};
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else if (ce) begin
			if (awready && awvalid) begin
				aw_addr_q <= awaddr;
				aw_held_q <= 1'b1;
				awready   <= 1'b0;
			end else if (!aw_held_q && !bvalid) begin
				awready <= 1'b1;
			end
			if (wready && wvalid) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				w_held_q <= 1'b1;
				wready   <= 1'b0;
			end else if (!w_held_q && !bvalid) begin
				wready <= 1'b1;
			end
			if (wr_fire) begin
				bvalid    <= 1'b1;
				bresp     <= wr_map ? `AORS_RESP_OK : `AORS_RESP_ERR;
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < NCONV; i = i + 1) begin
				rate_q[i] <= `AORS_RATE_RST; // [RL1]
			end
			for (i = 0; i < NPAIR; i = i + 1) begin
				pair_q[i] <= `AORS_PAIR_RST; // [RL9]
			end
		end else if (ce && wr_fire && w_strb_q[0]) begin
			if (wr_is_rate) begin
				rate_q[wr_off_r[2:0]] <= w_data_q[`AORS_RATE_MSB:`AORS_RATE_LSB]; // [RL1] [RL2]
			end
			if (wr_is_pair) begin
				pair_q[wr_off_p[4:0]] <= w_data_q[`AORS_PICK_MSB:`AORS_SRC_LSB]; // [RL9]
			end
		end
	end

	// ==========================================
	// Read channel
	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h0000_0000;
		if (rd_is_rate) begin
			rd_word[`AORS_RATE_MSB:`AORS_RATE_LSB] = rate_q[rd_off_r[2:0]];
		end else if (rd_is_pair) begin
			rd_word[`AORS_PICK_MSB:`AORS_SRC_LSB] = pair_q[rd_off_p[4:0]];
		end else if (rd_is_stat) begin
			rd_word = {serial_out_pair_active, resampler_rate_valid};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `AORS_RESP_OK;
		end else if (ce) begin
			if (arready && arvalid) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_word;
				rresp   <= rd_map ? `AORS_RESP_OK : `AORS_RESP_ERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end else if (!rvalid) begin
				arready <= 1'b1;
			end
		end
	end

	// ==========================================
	// Generator rate derivation
	always @(posedge aclk) begin
		if (!aresetn) begin
			g1_cnt_q <= 4'h0;
			g2_cnt_q <= 3'h0;
		end else if (ce) begin
			if (gen1_x4_tick) begin
				g1_cnt_q <= g1_cnt_q + 4'h1;
			end
			if (gen2_tick) begin
				g2_cnt_q <= (g2_cnt_q == `AORS_G2_D6_PH) ? 3'h0 : g2_cnt_q + 3'h1;
			end
		end
	end

	wire g1_x4 = gen1_x4_tick; // [RL5]
	wire g1_x2 = gen1_x4_tick && (g1_cnt_q[0] == `AORS_G1_X2_PH); // [RL5]
	wire g1_b  = gen1_x4_tick && (g1_cnt_q[1:0] == `AORS_G1_B_PH); // [RL5]
	wire g1_d2 = gen1_x4_tick && (g1_cnt_q[2:0] == `AORS_G1_D2_PH); // [RL6]
	wire g1_d4 = gen1_x4_tick && (g1_cnt_q == `AORS_G1_D4_PH); // [RL6]
	wire g2_d3 = gen2_tick && ((g2_cnt_q == `AORS_G2_D3_A) || (g2_cnt_q == `AORS_G2_D6_PH)); // [RL7]
	wire g2_d6 = gen2_tick && (g2_cnt_q == `AORS_G2_D6_PH); // [RL7]

	// ==========================================
	// Converter output timing select
	reg [NCONV-1:0] tick_d;
	reg [NCONV-1:0] valid_d;
	always @* begin
		tick_d  = {NCONV{1'b0}};
		valid_d = {NCONV{1'b0}};
		for (ic = 0; ic < NCONV; ic = ic + 1) begin
			valid_d[ic] = 1'b1;
			case (rate_q[ic])
				`AORS_RATE_PORT0: tick_d[ic] = sout_rate_tick[0]; // [RL3]
				`AORS_RATE_PORT1: tick_d[ic] = sout_rate_tick[1]; // [RL3]
				`AORS_RATE_PORT2: tick_d[ic] = sout_rate_tick[2]; // [RL3]
				`AORS_RATE_PORT3: tick_d[ic] = sout_rate_tick[3]; // [RL3]
				`AORS_RATE_DSP:   tick_d[ic] = dsp_rate_tick; // [RL4]
				`AORS_RATE_G1:    tick_d[ic] = g1_b; // [RL5]
				`AORS_RATE_G1X2:  tick_d[ic] = g1_x2; // [RL5]
				`AORS_RATE_G1X4:  tick_d[ic] = g1_x4; // [RL5]
				`AORS_RATE_G1D2:  tick_d[ic] = g1_d2; // [RL6]
				`AORS_RATE_G2D3:  tick_d[ic] = g2_d3; // [RL7]
				`AORS_RATE_G1D4:  tick_d[ic] = g1_d4; // [RL6]
				`AORS_RATE_G2D6:  tick_d[ic] = g2_d6; // [RL7]
				default:          valid_d[ic] = 1'b0; // [RL2] [RL17]
			endcase
		end
	end

	// Converters emit one output sample per tick, whatever their input rate
	always @(posedge aclk) begin
		if (!aresetn) begin
			resampler_rate_tick  <= {NCONV{1'b0}};
			resampler_rate_valid <= {NCONV{1'b0}};
		end else if (ce) begin
			resampler_rate_tick  <= tick_d; // [RL8]
			resampler_rate_valid <= valid_d; // [RL2]
		end
	end

	// ==========================================
	// Output pair routing
	reg [2*NPAIR*DW-1:0] out_d;
	reg [NPAIR-1:0]      act_d;
	reg [2:0]            src;
	reg [2:0]            pick;
	always @* begin
		out_d = {2*NPAIR*DW{1'b0}};
		act_d = {NPAIR{1'b0}};
		src   = `AORS_SRC_OFF;
		pick  = 3'h0;
		// Pair k lands on channels 2k, 2k+1; ports take 16, 16, 8, 8 channels in index order
		for (ip = 0; ip < NPAIR; ip = ip + 1) begin // [RL10] [RL11]
			src  = pair_q[ip][`AORS_SRC_MSB:`AORS_SRC_LSB];
			pick = pair_q[ip][`AORS_PICK_MSB:`AORS_PICK_LSB];
			act_d[ip] = 1'b1;
			case (src) // [RL14] [RL15]
				`AORS_SRC_SIN: out_d[2*ip*DW +: 2*DW] = serial_in_data[2*ip*DW +: 2*DW]; // [RL16]
				`AORS_SRC_DSP: out_d[2*ip*DW +: 2*DW] = dsp_out_data[2*ip*DW +: 2*DW]; // [RL16]
				`AORS_SRC_CONV: out_d[2*ip*DW +: 2*DW] = resampler_out_data[2*pick*DW +: 2*DW]; // [RL12] [RL13]
				`AORS_SRC_MIC0: out_d[2*ip*DW +: 2*DW] = mic_in_data[0 +: 2*DW]; // [RL15]
				`AORS_SRC_MIC1: out_d[2*ip*DW +: 2*DW] = mic_in_data[2*DW +: 2*DW]; // [RL15]
				default: act_d[ip] = 1'b0; // [RL15]
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			serial_out_data        <= {2*NPAIR*DW{1'b0}};
			serial_out_pair_active <= {NPAIR{1'b0}};
		end else if (ce) begin
			serial_out_data        <= out_d;
			serial_out_pair_active <= act_d;
		end
	end

endmodule

// ---- testbench/aors_routing_assertions.sv ----
`timescale 1ns/1ps
// ==========================================
// Bus and rate tick checks
module aors_routing_assertions #(
	parameter NCONV = 8
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             ce,
	input wire logic             awvalid,
	input wire logic             awready,
	input wire logic             wvalid,
	input wire logic             wready,
	input wire logic [1:0]       bresp,
	input wire logic             bvalid,
	input wire logic             bready,
	input wire logic             arvalid,
	input wire logic             arready,
	input wire logic [31:0]      rdata,
	input wire logic             rvalid,
	input wire logic             rready,
	input wire logic [3:0]       sout_rate_tick,
	input wire logic             dsp_rate_tick,
	input wire logic             gen1_x4_tick,
	input wire logic             gen2_tick,
	input wire logic [NCONV-1:0] resampler_rate_tick,
	input wire logic [NCONV-1:0] resampler_rate_valid
);
	wire any_src = |sout_rate_tick || dsp_rate_tick || gen1_x4_tick || gen2_tick;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_wr_answer: assert property (ce && awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("write answer late");
	a_rd_answer: assert property (ce && arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_ar_closed: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
	a_aw_closed: assert property (ce && awvalid && awready |=> !awready)
		else $error("write address taken twice");
	a_tick_rated: assert property ((resampler_rate_tick & ~resampler_rate_valid) == 0)
		else $error("tick without rate");
	a_tick_cause: assert property (|resampler_rate_tick |-> $past(any_src))
		else $error("tick without source");
endmodule
bind aors_audio_output_routing aors_routing_assertions #(.NCONV(NCONV)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.ce(ce), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.sout_rate_tick(sout_rate_tick), .dsp_rate_tick(dsp_rate_tick), .gen1_x4_tick(gen1_x4_tick),
	.gen2_tick(gen2_tick), .resampler_rate_tick(resampler_rate_tick), .resampler_rate_valid(resampler_rate_valid));

// ---- testbench/audio_output_routing_select_bench.sv ----
`timescale 1ns/1ps
`include "aors_consts.vh"
module audio_output_routing_select_bench;
	reg           aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, dsp_rate_tick, gen1_x4_tick, gen2_tick;
	reg  [17:0]   awaddr, araddr;
	reg  [31:0]   wdata, e32;
	reg  [3:0]    sout_rate_tick;
	reg  [1535:0] serial_in_data, dsp_out_data;
	reg  [511:0]  resampler_out_data;
	reg  [127:0]  mic_in_data;
	wire          awready, wready, bvalid, arready, rvalid;
	wire [1:0]    bresp, rresp;
	wire [31:0]   rdata;
	wire [7:0]    resampler_rate_tick, resampler_rate_valid;
	wire [1535:0] serial_out_data;
	wire [23:0]   serial_out_pair_active;
	integer       fails, total_checks, seed, k, r, n, i, t, d, drv;
	integer       m [0:31];
	integer       cnt_o [0:7];
	integer       cnt_s [0:4];
	aors_audio_output_routing DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sout_rate_tick(sout_rate_tick), .dsp_rate_tick(dsp_rate_tick), .gen1_x4_tick(gen1_x4_tick),
		.gen2_tick(gen2_tick), .resampler_rate_tick(resampler_rate_tick), .resampler_rate_valid(resampler_rate_valid),
		.serial_in_data(serial_in_data), .dsp_out_data(dsp_out_data), .resampler_out_data(resampler_out_data),
		.mic_in_data(mic_in_data), .serial_out_data(serial_out_data), .serial_out_pair_active(serial_out_pair_active));
	always #12.5 aclk = ~aclk;
	// ==========================================
	// Reporting and bus tasks
	task conclude;
		begin
			$display("checks %0d mismatches %0d", total_checks, fails);
			if (fails == 0 && total_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e, input string s);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
			end
		end
	endtask
	task wait_end;
		begin
			if (t == 0) begin
				fails = fails + 1;
				conclude;
			end
		end
	endtask
	task wr(input [15:0] x, input [31:0] v, input [1:0] er);
		begin
			@(posedge aclk);
			awaddr <= {x, 2'h0};
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (t = 40; t > 0; t = t - 1) begin
				@(posedge aclk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				if (bvalid) begin
					chk({30'h0, bresp}, {30'h0, er}, "bresp");
					bready <= 1'b0;
					t = -1;
				end
			end
			wait_end;
		end
	endtask
	task rd(input [15:0] x, input [31:0] e, input [1:0] er);
		begin
			@(posedge aclk);
			araddr <= {x, 2'h0};
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (t = 40; t > 0; t = t - 1) begin
				@(posedge aclk);
				if (arready) arvalid <= 1'b0;
				if (rvalid) begin
					chk(rdata, e, "rdata");
					chk({30'h0, rresp}, {30'h0, er}, "rresp");
					rready <= 1'b0;
					t = -1;
				end
			end
			wait_end;
		end
	endtask
	// ==========================================
	// Reference model
	function [15:0] ix(input integer j);
		ix = j < 8 ? `AORS_RATE_IDX_BASE + j : `AORS_PAIR_IDX_BASE + j - 8;
	endfunction
	function [31:0] stat(input integer u);
		begin
			stat = 0;
			for (u = 0; u < 32; u = u + 1)
				stat[u] = u < 8 ? m[u] >= 1 && m[u] <= 12 : m[u] % 8 >= 1 && m[u] % 8 <= 5;
		end
	endfunction
	function [31:0] och(input integer c);
		integer s, p;
		begin
			s = m[8 + c / 2] % 8;
			p = m[8 + c / 2] / 8;
			och = s == 1 ? serial_in_data[c*32+:32] : s == 2 ? dsp_out_data[c*32+:32] :
				s == 3 ? resampler_out_data[(p*2+c%2)*32+:32] : s == 4 ? mic_in_data[(c%2)*32+:32] :
				s == 5 ? mic_in_data[(2+c%2)*32+:32] : 32'h0;
		end
	endfunction
	function integer rexp(input integer c);
		case (c)
			1, 2, 3, 4: rexp = cnt_s[c-1];
			5: rexp = cnt_s[4];
			6: rexp = 24;
			7: rexp = 48;
			8: rexp = 96;
			9: rexp = 12;
			10: rexp = 16;
			11: rexp = 6;
			12: rexp = 8;
			default: rexp = 0;
		endcase
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dsp_rate_tick, gen1_x4_tick, gen2_tick} = 0;
		{awaddr, araddr, wdata, sout_rate_tick, serial_in_data, dsp_out_data, resampler_out_data, mic_in_data} = 0;
		ce = 1'b1;
		fails = 0;
		total_checks = 0;
		seed = 32'h245620d6;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 32; k = k + 1) begin
			m[k] = 0;
			rd(ix(k), 0, `AORS_RESP_OK);
		end
		$display("reset values done");
		for (r = 0; r < 2; r = r + 1) begin
			for (i = 0; i < 48; i = i + 1) begin
				serial_in_data[i*32+:32] <= $random(seed);
				dsp_out_data[i*32+:32] <= $random(seed);
				if (i < 16) resampler_out_data[i*32+:32] <= $random(seed);
				if (i < 4) mic_in_data[i*32+:32] <= $random(seed);
			end
			for (k = 0; k < 32; k = k + 1) begin
				d = $random(seed);
				if (k < 8) d[3:0] = k + 8 * r;
				else if (r == 0) d[2:0] = k;
				wr(ix(k), d, `AORS_RESP_OK);
				m[k] = d & (k < 8 ? 15 : 63);
			end
			for (k = 0; k < 32; k = k + 1)
				rd(ix(k), m[k], `AORS_RESP_OK);
			e32 = stat(0);
			rd(`AORS_STAT_IDX, e32, `AORS_RESP_OK);
			repeat (2) @(posedge aclk);
			for (i = 0; i < 48; i = i + 1)
				chk(serial_out_data[i*32+:32], och(i), "route");
			chk({8'h0, serial_out_pair_active}, e32 >> 8, "active");
			chk({24'h0, resampler_rate_valid}, e32 & 32'hFF, "rate valid");
			for (i = 0; i < 8; i = i + 1) cnt_o[i] = 0;
			for (i = 0; i < 5; i = i + 1) cnt_s[i] = 0;
			for (n = 0; n < 196; n = n + 1) begin
				@(posedge aclk);
				for (i = 0; i < 8; i = i + 1) cnt_o[i] = cnt_o[i] + resampler_rate_tick[i];
				drv = n < 192 ? $random(seed) : 0;
				for (i = 0; i < 5; i = i + 1) cnt_s[i] = cnt_s[i] + drv[i];
				sout_rate_tick <= drv[3:0];
				dsp_rate_tick <= drv[4];
				gen1_x4_tick <= n < 192 && n % 2 == 1;
				gen2_tick <= n < 192 && n % 4 == 0;
			end
			for (i = 0; i < 8; i = i + 1)
				chk(cnt_o[i], rexp(m[i]), "rate ticks");
			$display("routing and rate round done");
		end
		wr(`AORS_RATE_IDX_LAST + 16'h1, $random(seed), `AORS_RESP_ERR);
		rd(`AORS_RATE_IDX_LAST + 16'h1, 0, `AORS_RESP_ERR);
		wr(`AORS_PAIR_IDX_LAST + 16'h1, $random(seed), `AORS_RESP_ERR);
		wr(`AORS_STAT_IDX, 32'hFFFFFFFF, `AORS_RESP_OK);
		rd(`AORS_STAT_IDX, stat(0), `AORS_RESP_OK);
		for (k = 0; k < 32; k = k + 1)
			rd(ix(k), m[k], `AORS_RESP_OK);
		$display("unmapped access done");
		conclude;
	end
endmodule
